//--- core/pcc_pkg.sv
// package: constants for the clock source control block
package pcc_pkg;
  // register offsets (byte addresses, one word each)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DIV = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_SEL = 8'h0c;
  // control register fields
  localparam int CTRL_PWR = 0;
  localparam int CTRL_AUTO = 1;
  localparam int CTRL_TRK = 2;
  localparam int CTRL_LIE = 3;
  localparam int CTRL_BSEL = 4;
  // divider register fields
  localparam int DIV_REF_LSB = 0;
  localparam int DIV_MUL_LSB = 8;
  localparam int DIV_SLOW_LSB = 16;
  // select register fields
  localparam int SEL_MOD = 0;
  localparam int SEL_NET = 1;
  localparam int SEL_DBG = 2;
  // status register fields
  localparam int STAT_LOCK = 0;
  localparam int STAT_TRK = 1;
  localparam int STAT_IRQ = 2;
  localparam int STAT_STAB = 3;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0003;
  localparam logic [2:0] REF_RST = 3'h0;
  localparam logic [5:0] MUL_RST = 6'h00;
  localparam logic [5:0] SLOW_RST = 6'h01;
  // lock tolerances, in feedback counts per window
  localparam logic [7:0] WIN_LEN = 8'h40;
  localparam logic [7:0] TOL_LOCK = 8'h01;
  localparam logic [7:0] TOL_UNLOCK = 8'h03;
  localparam logic [7:0] TOL_TRK = 8'h03;
  localparam logic [7:0] TOL_UNT = 8'h06;
  // stabilization delay
  localparam int STAB_NS = 200000;
  localparam int CLK_NS = 100;
  localparam int STAB_CYC = (STAB_NS + CLK_NS - 1) / CLK_NS;
endpackage

//--- core/pcc_divider.sv
// module: programmable divider producing a one-cycle enable pulse
`timescale 1ns/1ns
`default_nettype none
module pcc_divider #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // control
  input wire logic en_i,
  input wire logic clr_i,
  input wire logic [W-1:0] ratio_i,
  // output
  output logic pulse_o
);
  logic [W-1:0] cnt;

  // counts en_i events, pulses once every ratio_i of them
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt <= '0;
      pulse_o <= 1'b0;
    end
    else if (clr_i)
    begin
      cnt <= '0;
      pulse_o <= 1'b0;
    end
    else
    begin
      pulse_o <= 1'b0;
      if (en_i)
      begin
        if (cnt >= ratio_i - W'(1))
        begin
          cnt <= '0;
          pulse_o <= 1'b1;
        end
        else
          cnt <= cnt + W'(1);
      end
    end
  end
endmodule // pcc_divider
`default_nettype wire

//--- core/pcc_lockdet.sv
// module: frequency comparator for lock and tracking detection
`timescale 1ns/1ns
`default_nettype none
module pcc_lockdet (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // inputs
  input wire logic run_i,
  input wire logic ref_tick_i,
  input wire logic fb_tick_i,
  // results
  output logic lock_o,
  output logic in_trk_o
);
  logic [7:0] ref_cnt;
  logic [7:0] fb_cnt;
  logic [7:0] diff;

  always_comb
  begin
    diff = (fb_cnt > pcc_pkg::WIN_LEN) ? fb_cnt - pcc_pkg::WIN_LEN : pcc_pkg::WIN_LEN - fb_cnt;
  end

  // compare feedback ticks against a window of reference ticks
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ref_cnt <= 8'h00;
      fb_cnt <= 8'h00;
      lock_o <= 1'b0;
      in_trk_o <= 1'b0;
    end
    else if (!run_i)
    begin
      ref_cnt <= 8'h00;
      fb_cnt <= 8'h00;
      lock_o <= 1'b0;
      in_trk_o <= 1'b0;
    end
    else
    begin
      if (fb_tick_i && fb_cnt != 8'hff)
        fb_cnt <= fb_cnt + 8'h01;
      if (ref_tick_i)
      begin
        if (ref_cnt == pcc_pkg::WIN_LEN - 8'h01)
        begin
          ref_cnt <= 8'h00;
          fb_cnt <= {7'h00, fb_tick_i};
          if (diff <= pcc_pkg::TOL_LOCK)
            lock_o <= 1'b1;
          else if (diff > pcc_pkg::TOL_UNLOCK)
            lock_o <= 1'b0;
          if (diff <= pcc_pkg::TOL_TRK)
            in_trk_o <= 1'b1;
          else if (diff > pcc_pkg::TOL_UNT)
            in_trk_o <= 1'b0;
        end
        else
          ref_cnt <= ref_cnt + 8'h01;
      end
    end
  end
endmodule // pcc_lockdet
`default_nettype wire

//--- core/pcc_top.sv
// module: clock source control with loop dividers and lock detection
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - slow divider: crystal by 4 to 252
// - module clock: peripheral or slow clock
// - network clock: crystal or base clock
// - debug clock: debug or bus clock
// - monitor runs from crystal clock directly
// - reference divider 1 to 8
// - loop multiplier 1 to 64
// - loop keeps running in wait mode
// - stop suspends loop; loop resumes at once, lock detection after delay
// - lock detector compares feedback and reference
// - tracking bit clear means acquisition
// - auto mode switches filter by itself
// - auto mode: tracking bit read-only, hysteresis
// - read-only lock bit with hysteresis
// - interrupt on lock toggle when enabled
// - manual mode keeps lock and interrupt
// - manual mode: software writes tracking bit
module pcc_top #(
  parameter int STAB_CYC = pcc_pkg::STAB_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // clock ticks, synchronous enables
  input wire logic xtal_tick_i,
  input wire logic loop_tick_i,
  input wire logic periph_tick_i,
  input wire logic debug_tick_i,
  input wire logic bus_tick_i,
  // power modes
  input wire logic wait_mode_i,
  input wire logic stop_mode_i,
  // clock enables out
  output logic ref_tick_o,
  output logic slow_tick_o,
  output logic module_tick_o,
  output logic network_tick_o,
  output logic debug_mod_tick_o,
  output logic monitor_tick_o,
  output logic base_tick_o,
  // loop control
  output logic loop_run_o,
  output logic [5:0] loop_mult_o,
  output logic filter_track_o,
  output logic lock_irq_o
);
  logic loop_power_on;
  logic self_bandwidth_select;
  logic manual_trk;
  logic lock_irq_enable;
  logic base_sel_loop;
  logic [2:0] ref_div;
  logic [5:0] loop_mult;
  logic [5:0] slow_div;
  logic sel_mod;
  logic sel_net;
  logic sel_dbg;
  logic lock_q;
  logic lock_prev;
  logic irq_pend;
  logic auto_trk;
  logic stab_done;
  logic [31:0] stab_cnt;
  logic ref_pulse;
  logic fb_pulse;
  logic slow_pulse;
  logic loop_run;
  logic filter_trk;
  logic base_tick;
  logic [31:0] next_rdata;

  // loop runs when powered and not stopped; wait has no effect
  assign loop_run = loop_power_on && !stop_mode_i;
  assign filter_trk = self_bandwidth_select ? auto_trk : manual_trk;
  assign base_tick = base_sel_loop ? loop_tick_i : xtal_tick_i;

  // control registers
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      loop_power_on <= pcc_pkg::CTRL_RST[pcc_pkg::CTRL_PWR];
      self_bandwidth_select <= pcc_pkg::CTRL_RST[pcc_pkg::CTRL_AUTO];
      manual_trk <= pcc_pkg::CTRL_RST[pcc_pkg::CTRL_TRK];
      lock_irq_enable <= pcc_pkg::CTRL_RST[pcc_pkg::CTRL_LIE];
      base_sel_loop <= pcc_pkg::CTRL_RST[pcc_pkg::CTRL_BSEL];
    end
    else if (wr_i && addr_i == pcc_pkg::ADDR_CTRL)
    begin
      loop_power_on <= wdata_i[pcc_pkg::CTRL_PWR];
      self_bandwidth_select <= wdata_i[pcc_pkg::CTRL_AUTO];
      if (!wdata_i[pcc_pkg::CTRL_AUTO])
        manual_trk <= wdata_i[pcc_pkg::CTRL_TRK];
      lock_irq_enable <= wdata_i[pcc_pkg::CTRL_LIE];
      base_sel_loop <= wdata_i[pcc_pkg::CTRL_BSEL];
    end
  end

  // divider and select registers
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ref_div <= pcc_pkg::REF_RST;
      loop_mult <= pcc_pkg::MUL_RST;
      slow_div <= pcc_pkg::SLOW_RST;
      sel_mod <= 1'b0;
      sel_net <= 1'b0;
      sel_dbg <= 1'b0;
    end
    else if (wr_i)
    begin
      if (addr_i == pcc_pkg::ADDR_DIV)
      begin
        ref_div <= wdata_i[pcc_pkg::DIV_REF_LSB +: 3];
        loop_mult <= wdata_i[pcc_pkg::DIV_MUL_LSB +: 6];
        slow_div <= (wdata_i[pcc_pkg::DIV_SLOW_LSB +: 6] == 6'h00) ? 6'h01 : wdata_i[pcc_pkg::DIV_SLOW_LSB +: 6];
      end
      if (addr_i == pcc_pkg::ADDR_SEL)
      begin
        sel_mod <= wdata_i[pcc_pkg::SEL_MOD];
        sel_net <= wdata_i[pcc_pkg::SEL_NET];
        sel_dbg <= wdata_i[pcc_pkg::SEL_DBG];
      end
    end
  end

  // reference divider, ratio field plus one
  pcc_divider #(
    .W(4)
  ) u_ref_div (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .en_i(xtal_tick_i),
    .clr_i(1'b0),
    .ratio_i({1'b0, ref_div} + 4'h1),
    .pulse_o(ref_pulse)
  );

  // feedback divider, loop output by multiplier
  pcc_divider #(
    .W(7)
  ) u_fb_div (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .en_i(loop_tick_i),
    .clr_i(!loop_run),
    .ratio_i({1'b0, loop_mult} + 7'h01),
    .pulse_o(fb_pulse)
  );

  // slow divider, field times four
  pcc_divider #(
    .W(8)
  ) u_slow_div (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .en_i(xtal_tick_i),
    .clr_i(1'b0),
    .ratio_i({slow_div, 2'b00}),
    .pulse_o(slow_pulse)
  );

  // lock detector, held until stabilization done
  pcc_lockdet u_lockdet (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .run_i(loop_run && stab_done),
    .ref_tick_i(ref_pulse),
    .fb_tick_i(fb_pulse),
    .lock_o(lock_q),
    .in_trk_o(auto_trk)
  );

  // stabilization delay after power on or stop exit
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      stab_cnt <= 32'h0000_0000;
      stab_done <= 1'b0;
    end
    else if (!loop_run)
    begin
      stab_cnt <= 32'h0000_0000;
      stab_done <= 1'b0;
    end
    else if (!stab_done)
    begin
      if (stab_cnt >= 32'(STAB_CYC - 1))
        stab_done <= 1'b1;
      else
        stab_cnt <= stab_cnt + 32'h0000_0001;
    end
  end

  // lock toggle detection and pending flag, set wins
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      lock_prev <= 1'b0;
      irq_pend <= 1'b0;
    end
    else
    begin
      lock_prev <= lock_q;
      if (lock_q != lock_prev)
        irq_pend <= 1'b1;
      else if (wr_i && addr_i == pcc_pkg::ADDR_STAT && wdata_i[pcc_pkg::STAT_IRQ])
        irq_pend <= 1'b0;
    end
  end

  // divided ticks
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ref_tick_o <= 1'b0;
      slow_tick_o <= 1'b0;
    end
    else
    begin
      ref_tick_o <= ref_pulse;
      slow_tick_o <= slow_pulse;
    end
  end

  // monitor tick, crystal only, no loop path
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      monitor_tick_o <= 1'b0;
    end
    else
    begin
      monitor_tick_o <= xtal_tick_i;
    end
  end

  // selected source ticks
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      module_tick_o <= 1'b0;
      network_tick_o <= 1'b0;
      debug_mod_tick_o <= 1'b0;
      base_tick_o <= 1'b0;
    end
    else
    begin
      module_tick_o <= sel_mod ? slow_pulse : periph_tick_i;
      network_tick_o <= sel_net ? base_tick : xtal_tick_i;
      debug_mod_tick_o <= sel_dbg ? bus_tick_i : debug_tick_i;
      base_tick_o <= base_tick;
    end
  end

  // loop outputs
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      loop_run_o <= 1'b0;
      loop_mult_o <= 6'h00;
      filter_track_o <= 1'b0;
    end
    else
    begin
      loop_run_o <= loop_run && !(wait_mode_i && 1'b0);
      loop_mult_o <= loop_mult;
      filter_track_o <= filter_trk && loop_run;
    end
  end

  // interrupt request, pending flag gated by enable
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      lock_irq_o <= 1'b0;
    end
    else
    begin
      lock_irq_o <= irq_pend && lock_irq_enable;
    end
  end

  // read mux
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (addr_i)
      pcc_pkg::ADDR_CTRL:
      begin
        next_rdata[pcc_pkg::CTRL_PWR] = loop_power_on;
        next_rdata[pcc_pkg::CTRL_AUTO] = self_bandwidth_select;
        next_rdata[pcc_pkg::CTRL_TRK] = filter_trk;
        next_rdata[pcc_pkg::CTRL_LIE] = lock_irq_enable;
        next_rdata[pcc_pkg::CTRL_BSEL] = base_sel_loop;
      end
      pcc_pkg::ADDR_DIV:
      begin
        next_rdata[pcc_pkg::DIV_REF_LSB +: 3] = ref_div;
        next_rdata[pcc_pkg::DIV_MUL_LSB +: 6] = loop_mult;
        next_rdata[pcc_pkg::DIV_SLOW_LSB +: 6] = slow_div;
      end
      pcc_pkg::ADDR_STAT:
      begin
        next_rdata[pcc_pkg::STAT_LOCK] = lock_q;
        next_rdata[pcc_pkg::STAT_TRK] = filter_trk;
        next_rdata[pcc_pkg::STAT_IRQ] = irq_pend;
        next_rdata[pcc_pkg::STAT_STAB] = stab_done;
      end
      pcc_pkg::ADDR_SEL:
      begin
        next_rdata[pcc_pkg::SEL_MOD] = sel_mod;
        next_rdata[pcc_pkg::SEL_NET] = sel_net;
        next_rdata[pcc_pkg::SEL_DBG] = sel_dbg;
      end
      default:
        next_rdata = 32'h0000_0000;
    endcase
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_o <= 32'h0000_0000;
    else
      rdata_o <= rd_i ? next_rdata : 32'h0000_0000;
  end
endmodule // pcc_top
`default_nettype wire

//--- verification/pcc_checker.sv
// checker: port-level assertions for the clock source control block
`timescale 1ns/1ns
`default_nettype none
module pcc_checker #(
  parameter int STAB_CYC = 20
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  // ticks and modes
  input wire logic xtal_tick_i,
  input wire logic loop_tick_i,
  input wire logic periph_tick_i,
  input wire logic debug_tick_i,
  input wire logic bus_tick_i,
  input wire logic stop_mode_i,
  // watched outputs
  input wire logic slow_tick_o,
  input wire logic base_tick_o,
  input wire logic module_tick_o,
  input wire logic network_tick_o,
  input wire logic debug_mod_tick_o,
  input wire logic monitor_tick_o,
  input wire logic loop_run_o,
  input wire logic [5:0] loop_mult_o,
  input wire logic filter_track_o,
  input wire logic lock_irq_o
);
  logic [4:0] ctrl_q;
  logic [2:0] sel_q;
  logic [5:0] mul_q;
  logic live_q;
  // shadow of the written control, select and multiplier fields
  always_ff @(posedge mclk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      ctrl_q <= 5'h03;
      sel_q <= 3'h0;
      mul_q <= 6'h00;
    end
    else if (wr_i)
    begin
      if (addr_i == pcc_pkg::ADDR_CTRL)
        ctrl_q <= {wdata_i[4:3], wdata_i[1] ? ctrl_q[2] : wdata_i[2], wdata_i[1:0]};
      if (addr_i == pcc_pkg::ADDR_SEL)
        sel_q <= wdata_i[2:0];
      if (addr_i == pcc_pkg::ADDR_DIV)
        mul_q <= wdata_i[13:8];
    end
  // assertions start one cycle after reset release
  always_ff @(posedge mclk_i or negedge rstn_i)
    if (!rstn_i)
      live_q <= 1'b0;
    else
      live_q <= 1'b1;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i || !live_q);
  sequence manual_steady_s;
    (ctrl_q[0] && !ctrl_q[1] && !stop_mode_i && $stable(ctrl_q)) [*2];
  endsequence
  mod_tick_periph_a: assert property (!sel_q[0] |=> module_tick_o == $past(periph_tick_i))
    else $error("module tick does not follow peripheral tick");
  net_tick_xtal_a: assert property (!sel_q[1] |=> network_tick_o == $past(xtal_tick_i))
    else $error("network tick does not follow crystal tick");
  dbg_tick_mux_a: assert property (1'b1 |=> debug_mod_tick_o == $past(sel_q[2] ? bus_tick_i : debug_tick_i))
    else $error("debug tick source wrong");
  monitor_tick_a: assert property (1'b1 |=> monitor_tick_o == $past(xtal_tick_i))
    else $error("monitor tick not from crystal");
  loop_run_mode_a: assert property (1'b1 |=> loop_run_o == $past(ctrl_q[0] && !stop_mode_i))
    else $error("loop run level wrong");
  loop_mult_a: assert property (1'b1 |=> loop_mult_o == $past(mul_q))
    else $error("multiplier output wrong");
  track_off_a: assert property (!ctrl_q[0] [*2] |-> !filter_track_o)
    else $error("tracking while loop off");
  manual_track_a: assert property (manual_steady_s |-> filter_track_o == ctrl_q[2])
    else $error("manual filter mode not applied");
  irq_masked_a: assert property (!ctrl_q[3] |=> !lock_irq_o)
    else $error("interrupt while disabled");
  mod_tick_slow_a: assert property (sel_q[0] |=> module_tick_o == slow_tick_o)
    else $error("module tick does not follow slow tick");
  net_tick_base_a: assert property (sel_q[1] |=> network_tick_o == base_tick_o)
    else $error("network tick does not follow base tick");
  base_tick_sel_a: assert property (1'b1 |=> base_tick_o == $past(ctrl_q[4] ? loop_tick_i : xtal_tick_i))
    else $error("base tick source wrong");
endmodule // pcc_checker
`default_nettype wire

//--- verification/tb_top.sv
// testbench: register-driven checks of the clock source control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic xtal_tick_i = 1'b0;
  logic loop_tick_i = 1'b0;
  logic periph_tick_i = 1'b0;
  logic debug_tick_i = 1'b0;
  logic bus_tick_i = 1'b0;
  logic wait_mode_i = 1'b0;
  logic stop_mode_i = 1'b0;
  logic lp_en = 1'b1;
  logic [7:0] cyc = 8'h00;
  logic [31:0] rdata_o;
  logic ref_tick_o, slow_tick_o, module_tick_o, network_tick_o, debug_mod_tick_o, monitor_tick_o, base_tick_o;
  logic loop_run_o, filter_track_o, lock_irq_o;
  logic [5:0] loop_mult_o;
  int n_mismatch = 0;
  int check_count = 0;
  logic [31:0] q;
  int cr, cs;

  pcc_top #(.STAB_CYC(20)) pcc_top_i (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .xtal_tick_i(xtal_tick_i), .loop_tick_i(loop_tick_i),
    .periph_tick_i(periph_tick_i), .debug_tick_i(debug_tick_i), .bus_tick_i(bus_tick_i),
    .wait_mode_i(wait_mode_i), .stop_mode_i(stop_mode_i), .ref_tick_o(ref_tick_o), .slow_tick_o(slow_tick_o),
    .module_tick_o(module_tick_o), .network_tick_o(network_tick_o), .debug_mod_tick_o(debug_mod_tick_o),
    .monitor_tick_o(monitor_tick_o), .base_tick_o(base_tick_o), .loop_run_o(loop_run_o),
    .loop_mult_o(loop_mult_o), .filter_track_o(filter_track_o), .lock_irq_o(lock_irq_o));

  always #50 mclk_i = ~mclk_i;

  // clock enables standing for the crystal and other sources
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 8'h01;
    xtal_tick_i <= cyc[0];
    loop_tick_i <= lp_en & cyc[0];
    periph_tick_i <= cyc[1];
    debug_tick_i <= cyc[2];
    bus_tick_i <= cyc[3];
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    q = rdata_o;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    rd(a);
    chk(nm, exp, q);
  endtask

  task automatic waitlock(input logic v);
    for (int i = 0; i < 300; i++)
    begin
      rd(pcc_pkg::ADDR_STAT);
      if (q[0] === v)
        break;
    end
    chk("lock bit", {31'h0, v}, {31'h0, q[0]});
    if (q[0] !== v)
      end_of_test();
  endtask

  task automatic count(input int n);
    cr = 0;
    cs = 0;
    repeat (n) @(negedge mclk_i)
    begin
      cr += int'(ref_tick_o);
      cs += int'(slow_tick_o);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge mclk_i);
    rstn_i <= 1'b1;
    rdc(pcc_pkg::ADDR_CTRL, pcc_pkg::CTRL_RST, "ctrl reset");
    rdc(pcc_pkg::ADDR_DIV, 32'h0001_0000, "div reset");
    rdc(pcc_pkg::ADDR_SEL, 32'h0, "sel reset");
    rdc(8'h10, 32'h0, "unmapped read");
    $display("test done: reset values");
    for (int r = 0; r < 8; r++)
    begin
      wr(pcc_pkg::ADDR_DIV, 32'h0001_0000 | (r * 9) << 8 | r);
      count(480);
      chk("ref tick count near", 1, 32'((cr - 240 / (r + 1)) inside {[-1:1]}));
      chk("slow tick count near", 1, 32'((cs - 60) inside {[-1:1]}));
      chk("multiplier", 32'(r * 9), {26'h0, loop_mult_o});
    end
    wr(pcc_pkg::ADDR_DIV, 32'h003f_0000);
    count(2016);
    chk("slow tick count near", 1, 32'((cs - 4) inside {[-1:1]}));
    wr(pcc_pkg::ADDR_DIV, 32'h0001_0000);
    $display("test done: dividers");
    wr(pcc_pkg::ADDR_SEL, 32'h7);
    repeat (40) @(posedge mclk_i);
    rdc(pcc_pkg::ADDR_SEL, 32'h7, "sel readback");
    wr(pcc_pkg::ADDR_SEL, 32'h0);
    $display("test done: clock selects");
    wait_mode_i <= 1'b1;
    repeat (10) @(negedge mclk_i);
    chk("loop run in wait", 1, {31'h0, loop_run_o});
    @(posedge mclk_i);
    wait_mode_i <= 1'b0;
    stop_mode_i <= 1'b1;
    repeat (3) @(negedge mclk_i);
    chk("loop run in stop", 0, {31'h0, loop_run_o});
    @(posedge mclk_i);
    stop_mode_i <= 1'b0;
    repeat (3) @(negedge mclk_i);
    chk("loop run after stop", 1, {31'h0, loop_run_o});
    $display("test done: power modes");
    wr(pcc_pkg::ADDR_CTRL, 32'h0b);
    waitlock(1'b1);
    rdc(pcc_pkg::ADDR_STAT, 32'h0f, "status locked");
    chk("tracking auto", 1, {31'h0, filter_track_o});
    chk("irq on lock", 1, {31'h0, lock_irq_o});
    wr(pcc_pkg::ADDR_STAT, 32'h4);
    repeat (3) @(negedge mclk_i);
    chk("irq cleared", 0, {31'h0, lock_irq_o});
    wr(pcc_pkg::ADDR_CTRL, 32'h1b);
    repeat (3) @(negedge mclk_i);
    chk("tracking read only", 1, {31'h0, filter_track_o});
    lp_en <= 1'b0;
    waitlock(1'b0);
    repeat (2) @(negedge mclk_i);
    chk("irq on unlock", 1, {31'h0, lock_irq_o});
    chk("acquisition auto", 0, {31'h0, filter_track_o});
    wr(pcc_pkg::ADDR_CTRL, 32'h03);
    repeat (3) @(negedge mclk_i);
    chk("irq masked", 0, {31'h0, lock_irq_o});
    $display("test done: lock and interrupt");
    wr(pcc_pkg::ADDR_CTRL, 32'h00);
    lp_en <= 1'b1;
    wr(pcc_pkg::ADDR_CTRL, 32'h01);
    repeat (40) @(negedge mclk_i);
    chk("manual acquisition", 0, {31'h0, filter_track_o});
    wr(pcc_pkg::ADDR_CTRL, 32'h05);
    repeat (3) @(negedge mclk_i);
    chk("manual tracking", 1, {31'h0, filter_track_o});
    rdc(pcc_pkg::ADDR_CTRL, 32'h05, "ctrl manual");
    waitlock(1'b1);
    $display("test done: manual mode");
    end_of_test();
  end
endmodule // tb_top

bind pcc_top pcc_checker #(.STAB_CYC(STAB_CYC)) pcc_checker_i (.mclk_i(mclk_i), .rstn_i(rstn_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .xtal_tick_i(xtal_tick_i), .periph_tick_i(periph_tick_i),
  .debug_tick_i(debug_tick_i), .bus_tick_i(bus_tick_i), .stop_mode_i(stop_mode_i), .loop_tick_i(loop_tick_i),
  .slow_tick_o(slow_tick_o), .base_tick_o(base_tick_o),
  .module_tick_o(module_tick_o), .network_tick_o(network_tick_o), .debug_mod_tick_o(debug_mod_tick_o),
  .monitor_tick_o(monitor_tick_o), .loop_run_o(loop_run_o), .loop_mult_o(loop_mult_o),
  .filter_track_o(filter_track_o), .lock_irq_o(lock_irq_o));
`default_nettype wire
